// ---- src/sfm_defines.vh ----
// Function
// - modify commands need write latch set first
// - page write erases page, keeps unsupplied bytes
// - data past page end wraps to start
// - over 256 bytes, only last 256 kept
// - under 256 bytes, others in page untouched
// - write/program need select rise on byte boundary
// - select rise starts cycle, busy, latch clears
// - page write refused on hw/sw protection
// - program clears bits only, refused hw only
// - program refused on hardware protected page
// - modify commands rejected while cycle busy
// - lock write needs exactly one data byte
// - lock bits instant, latch clears quickly
// - page erase sets page to FFh
// - erase needs select rise after address
// - page erase refused on hw/sw protection
// - subsector erase sets subsector to ones
// - subsector erase refused on protected sector
// - reset pin aborts erase, enters reset mode
// - ignore top address bits per variant
// - serial input sampled on clock rise
// - lock-down freezes sector lock bits
// - write-locked sector skips all modify operations; lock writes to that sector still apply
`ifndef SFM_DEFINES_VH
`define SFM_DEFINES_VH

// system clock rate
`define SFM_CLK_MHZ               50

// address width per memory variant
`define SFM_ADDR_BITS_2M          18
`define SFM_ADDR_BITS_1M          17
`define SFM_SECTOR_LSB            16

// command codes, values arbitrary
`define SFM_OP_PAGE_WRITE         8'h11
`define SFM_OP_PAGE_PROGRAM       8'h12
`define SFM_OP_LOCK_WRITE         8'h13
`define SFM_OP_PAGE_ERASE         8'h14
`define SFM_OP_SUBSECTOR_ERASE    8'h15

// operation kinds shown to the array
`define SFM_KIND_PAGE_WRITE       2'h0
`define SFM_KIND_PAGE_PROGRAM     2'h1
`define SFM_KIND_PAGE_ERASE       2'h2
`define SFM_KIND_SUBSECTOR_ERASE  2'h3

// lock byte fields
`define SFM_LOCK_WLOCK_BIT        0
`define SFM_LOCK_LDOWN_BIT        1
`define SFM_LOCK_WLOCK_RST        1'b0
`define SFM_LOCK_LDOWN_RST        1'b0

// frame byte positions
`define SFM_BYTE_DATA             3'h4

// times in their own units
`define SFM_PROGRAM_CYCLE_TIME_US    1000
`define SFM_PAGE_ERASE_TIME_US       2000
`define SFM_SUBSECTOR_ERASE_TIME_US  4000
`define SFM_RESET_TO_SELECT_TIME_NS  30000
`define SFM_DESELECT_MIN_TIME_NS     100

// derived cycle counts
`define SFM_PROGRAM_CYCLES   (`SFM_PROGRAM_CYCLE_TIME_US * `SFM_CLK_MHZ)
`define SFM_PAGE_ERASE_CYCLES (`SFM_PAGE_ERASE_TIME_US * `SFM_CLK_MHZ)
`define SFM_SUBSECTOR_CYCLES (`SFM_SUBSECTOR_ERASE_TIME_US * `SFM_CLK_MHZ)
`define SFM_RST_SEL_CYCLES   ((`SFM_RESET_TO_SELECT_TIME_NS * `SFM_CLK_MHZ + 999) / 1000)

// timer width
`define SFM_TMR_W                 32

`endif

// ---- src/sfm_sync.v ----
`timescale 1ns/1ns
module sfm_sync #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire mclk_i,
  input  wire sys_rst_i,
  // pin side
  input  wire pin_i,
  // filtered level
  output reg  level_o
);

  reg s1;  // first stage, read only by s2
  reg s2;  // second stage
  reg s3;  // third stage

  ////////////////////////////////////////////////////////////////////////////
  // three stage chain, level moves once stages two and three agree
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1      <= RESET_VAL;
      s2      <= RESET_VAL;
      s3      <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;  // agreed value
      end
    end
  end

endmodule

// ---- src/sfm_timer.v ----
`timescale 1ns/1ns
`include "sfm_defines.vh"
module sfm_timer #(
  parameter W = `SFM_TMR_W
) (
  // clock and reset
  input  wire         mclk_i,
  input  wire         sys_rst_i,
  // control
  input  wire         start_i,
  input  wire [W-1:0] load_i,
  input  wire         abort_i,
  // status
  output reg          busy_o,
  output reg          done_o
);

  reg [W-1:0] remain;  // cycles left in the running cycle

  ////////////////////////////////////////////////////////////////////////////
  // self-timed down counter, abort wins, done pulses at natural end only
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      remain <= {W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        remain <= {W{1'b0}};
        busy_o <= 1'b0;
      end else if (start_i && !busy_o) begin
        remain <= load_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remain <= remain - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- src/sfm_top.v ----
`timescale 1ns/1ns
`include "sfm_defines.vh"
module sfm_top #(
  parameter ADDR_BITS = `SFM_ADDR_BITS_2M,
  parameter [7:0] OP_PAGE_WRITE = `SFM_OP_PAGE_WRITE,
  parameter [7:0] OP_PAGE_PROGRAM = `SFM_OP_PAGE_PROGRAM,
  parameter [7:0] OP_LOCK_WRITE = `SFM_OP_LOCK_WRITE,
  parameter [7:0] OP_PAGE_ERASE = `SFM_OP_PAGE_ERASE,
  parameter [7:0] OP_SUBSECTOR_ERASE = `SFM_OP_SUBSECTOR_ERASE,
  parameter [`SFM_TMR_W-1:0] PROGRAM_CYC = `SFM_PROGRAM_CYCLES,
  parameter [`SFM_TMR_W-1:0] PAGE_ERASE_CYC = `SFM_PAGE_ERASE_CYCLES,
  parameter [`SFM_TMR_W-1:0] SUBSECTOR_CYC = `SFM_SUBSECTOR_CYCLES
) (
  // system
  input  wire                           mclk_i,
  input  wire                           sys_rst_i,
  // serial link pins
  input  wire                           spi_cs_n_i,
  input  wire                           spi_sclk_i,
  input  wire                           serial_in_line_i,
  input  wire                           hw_reset_n_i,
  // write latch control from the other command handlers
  input  wire                           wel_set_i,
  input  wire                           wel_clr_i,
  // protection lookup for prot_addr_o
  input  wire                           hw_prot_i,
  input  wire                           sw_prot_i,
  // page buffer and lock read ports
  input  wire [7:0]                     buf_idx_i,
  input  wire [ADDR_BITS-`SFM_SECTOR_LSB-1:0] lock_sector_i,
  // status
  output reg                            write_latch_flag_o,
  output wire                           cycle_busy_flag_o,
  output wire                           reset_mode_o,
  // frame address for the protection lookup
  output wire [ADDR_BITS-1:0]           prot_addr_o,
  // array operation port
  output reg                            op_start_o,
  output reg  [1:0]                     op_kind_o,
  output reg  [ADDR_BITS-1:0]           op_addr_o,
  output wire                           op_done_o,
  output reg                            op_abort_o,
  // read data
  output reg  [7:0]                     buf_data_o,
  output reg                            buf_valid_o,
  output reg  [7:0]                     lock_rd_o
);

  localparam SECT_W  = ADDR_BITS - `SFM_SECTOR_LSB;  // sector index width
  localparam SECTORS = 1 << SECT_W;                  // sectors in the array
  localparam [`SFM_TMR_W-1:0] RST_SEL_CYC = `SFM_RST_SEL_CYCLES;
  localparam [`SFM_TMR_W-1:0] PW_CYC = PAGE_ERASE_CYC + PROGRAM_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire cs_n_s;   // filtered select
  wire sclk_s;   // filtered serial clock
  wire si_s;     // filtered serial input
  wire rstn_s;   // filtered reset pin

  sfm_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (spi_cs_n_i),
    .level_o   (cs_n_s)
  );
  sfm_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (spi_sclk_i),
    .level_o   (sclk_s)
  );
  sfm_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (serial_in_line_i),
    .level_o   (si_s)
  );
  sfm_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (hw_reset_n_i),
    .level_o   (rstn_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and reset-mode guard

  reg                  sclk_q;     // previous serial clock level
  reg                  cs_n_q;     // previous select level
  reg [`SFM_TMR_W-1:0] guard_cnt;  // select lockout after reset pin release

  wire sclk_rise = sclk_s & ~sclk_q;
  wire cs_rise   = cs_n_s & ~cs_n_q;
  wire cs_fall   = ~cs_n_s & cs_n_q;
  wire rst_mode  = ~rstn_s | (guard_cnt != {`SFM_TMR_W{1'b0}});

  assign reset_mode_o = rst_mode;

  // edge history and lockout counter
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      guard_cnt <= {`SFM_TMR_W{1'b0}};
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      if (!rstn_s) begin
        guard_cnt <= RST_SEL_CYC;
      end else if (guard_cnt != {`SFM_TMR_W{1'b0}}) begin
        guard_cnt <= guard_cnt - {{(`SFM_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame capture

  reg        in_frame;  // select taken while not in reset mode
  reg [2:0]  bit_cnt;   // bits of the current byte
  reg [2:0]  byte_pos;  // 0 opcode, 1..3 address, 4 data
  reg [6:0]  shift;     // partial byte
  reg [7:0]  opcode;    // captured command code
  reg [23:0] addr;      // captured address
  reg [7:0]  data_idx;  // wrapping offset of next data byte from the start address
  reg [1:0]  data_cnt;  // data bytes seen, saturates at 2
  reg [7:0]  lock_byte; // last data byte, for lock writes
  reg        armed;     // latch set and idle at opcode time

  wire       bit_take  = in_frame & ~cs_n_s & sclk_rise;
  wire       byte_done = bit_take & (bit_cnt == 3'h7);
  wire [7:0] new_byte  = {shift, si_s};
  wire       is_pw     = (opcode == OP_PAGE_WRITE);
  wire       is_pp     = (opcode == OP_PAGE_PROGRAM);
  wire       is_lw     = (opcode == OP_LOCK_WRITE);
  wire       is_pe     = (opcode == OP_PAGE_ERASE);
  wire       is_sse    = (opcode == OP_SUBSECTOR_ERASE);
  wire       new_pwpp  = (new_byte == OP_PAGE_WRITE) | (new_byte == OP_PAGE_PROGRAM);
  wire       in_data   = (byte_pos == `SFM_BYTE_DATA);
  wire [7:0] wr_idx    = addr[7:0] + data_idx;

  wire [ADDR_BITS-1:0] addr_m = addr[ADDR_BITS-1:0];
  wire [SECT_W-1:0]    sect   = addr[ADDR_BITS-1:`SFM_SECTOR_LSB];

  assign prot_addr_o = addr_m;

  // shift opcode, address and data bits on each serial clock rise
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      in_frame  <= 1'b0;
      bit_cnt   <= 3'h0;
      byte_pos  <= 3'h0;
      shift     <= 7'h00;
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      data_idx  <= 8'h00;
      data_cnt  <= 2'h0;
      lock_byte <= 8'h00;
      armed     <= 1'b0;
    end else if (rst_mode || cs_n_s) begin
      in_frame <= 1'b0;  // frame dropped by reset pin or ended
    end else if (cs_fall) begin
      // new frame
      in_frame <= 1'b1;
      bit_cnt  <= 3'h0;
      byte_pos <= 3'h0;
      data_idx <= 8'h00;
      data_cnt <= 2'h0;
      armed    <= 1'b0;
    end else if (bit_take) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= new_byte[6:0];
      if (byte_done) begin
        case (byte_pos)
          3'h0: begin
            opcode <= new_byte;
            armed  <= write_latch_flag_o & ~cycle_busy_flag_o;
          end
          3'h1: addr[23:16] <= new_byte;
          3'h2: addr[15:8]  <= new_byte;
          3'h3: addr[7:0]   <= new_byte;
          default: begin
            lock_byte <= new_byte;
            data_idx  <= data_idx + 8'h01;
            if (data_cnt != 2'h2) begin
              data_cnt <= data_cnt + 2'h1;
            end
          end
        endcase
        if (!in_data) begin
          byte_pos <= byte_pos + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page buffer, one byte and one valid flag per page offset

  reg [7:0]   page_mem [0:255];  // supplied data bytes
  reg [255:0] page_vld;          // offsets supplied this frame

  // clear at an armed write opcode, fill from data bytes
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      page_vld <= 256'h0;
    end else if (byte_done && byte_pos == 3'h0 && new_pwpp &&
                 write_latch_flag_o && !cycle_busy_flag_o) begin
      page_vld <= 256'h0;
    end else if (byte_done && in_data && armed && (is_pw || is_pp)) begin
      page_vld[wr_idx] <= 1'b1;  // later bytes overwrite earlier
    end
  end

  // data storage needs no reset
  always @(posedge mclk_i) begin
    if (byte_done && in_data && armed && (is_pw || is_pp)) begin
      page_mem[wr_idx] <= new_byte;
    end
  end

  // registered read port for the array
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      buf_data_o  <= 8'h00;
      buf_valid_o <= 1'b0;
    end else begin
      buf_data_o  <= page_mem[buf_idx_i];
      buf_valid_o <= page_vld[buf_idx_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end-of-frame decision

  reg [SECTORS-1:0] wlock;  // per sector write lock
  reg [SECTORS-1:0] ldown;  // per sector lock-down

  wire on_byte  = (bit_cnt == 3'h0);
  wire end_ok   = in_frame & cs_rise & armed & on_byte & ~cycle_busy_flag_o;
  wire wlock_s  = wlock[sect];
  wire pw_go    = end_ok & is_pw & in_data & (data_cnt != 2'h0)
                  & ~hw_prot_i & ~sw_prot_i & ~wlock_s;
  wire pp_go    = end_ok & is_pp & in_data & (data_cnt != 2'h0)
                  & ~hw_prot_i & ~wlock_s;
  wire pe_go    = end_ok & is_pe & in_data & (data_cnt == 2'h0)
                  & ~hw_prot_i & ~sw_prot_i & ~wlock_s;
  wire sse_go   = end_ok & is_sse & in_data & (data_cnt == 2'h0)
                  & ~hw_prot_i & ~sw_prot_i & ~wlock_s;
  wire lw_go    = end_ok & is_lw & in_data & (data_cnt == 2'h1);
  wire op_go    = pw_go | pp_go | pe_go | sse_go;

  reg [1:0]            next_kind;  // kind of the starting cycle
  reg [`SFM_TMR_W-1:0] next_load;  // duration of the starting cycle

  // pick kind and duration
  always @* begin
    next_kind = `SFM_KIND_SUBSECTOR_ERASE;
    next_load = SUBSECTOR_CYC;
    if (pw_go) begin
      next_kind = `SFM_KIND_PAGE_WRITE;
      next_load = PW_CYC;  // erase then program
    end else if (pp_go) begin
      next_kind = `SFM_KIND_PAGE_PROGRAM;
      next_load = PROGRAM_CYC;
    end else if (pe_go) begin
      next_kind = `SFM_KIND_PAGE_ERASE;
      next_load = PAGE_ERASE_CYC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed cycle

  sfm_timer #(.W(`SFM_TMR_W)) u_timer (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (op_go),
    .load_i    (next_load),
    .abort_i   (~rstn_s),
    .busy_o    (cycle_busy_flag_o),
    .done_o    (op_done_o)
  );

  // array request registers, abort pulse on reset pin during a cycle
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      op_start_o <= 1'b0;
      op_kind_o  <= `SFM_KIND_PAGE_WRITE;
      op_addr_o  <= {ADDR_BITS{1'b0}};
      op_abort_o <= 1'b0;
    end else begin
      op_start_o <= op_go;
      op_abort_o <= ~rstn_s & cycle_busy_flag_o;
      if (op_go) begin
        op_kind_o <= next_kind;
        op_addr_o <= addr_m;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write latch: device clears, the set request wins

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      write_latch_flag_o <= 1'b0;
    end else begin
      if (op_go || lw_go || wel_clr_i || !rstn_s) begin
        write_latch_flag_o <= 1'b0;
      end
      if (wel_set_i) begin
        write_latch_flag_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volatile sector lock bits

  // update at once, frozen by lock-down until power-up
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wlock <= {SECTORS{`SFM_LOCK_WLOCK_RST}};
      ldown <= {SECTORS{`SFM_LOCK_LDOWN_RST}};
    end else if (lw_go && !ldown[sect]) begin
      wlock[sect] <= lock_byte[`SFM_LOCK_WLOCK_BIT];
      ldown[sect] <= lock_byte[`SFM_LOCK_LDOWN_BIT];
    end
  end

  // registered lock read port, upper bits zero
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lock_rd_o <= 8'h00;
    end else begin
      lock_rd_o <= {6'h00, ldown[lock_sector_i], wlock[lock_sector_i]};
    end
  end

endmodule

// ---- verif/sfm_top_asserts.sv ----
`timescale 1ns/1ns
module sfm_top_asserts #(
  parameter        ADDR_BITS      = 18,
  parameter [31:0] PROGRAM_CYC    = 20,
  parameter [31:0] PAGE_ERASE_CYC = 20,
  parameter [31:0] SUBSECTOR_CYC  = 20
) (
  // system
  input wire                 mclk_i,
  input wire                 sys_rst_i,
  // pins and latch control
  input wire                 spi_cs_n_i,
  input wire                 hw_reset_n_i,
  input wire                 wel_set_i,
  // status and array port
  input wire                 write_latch_flag_o,
  input wire                 cycle_busy_flag_o,
  input wire                 reset_mode_o,
  input wire                 op_start_o,
  input wire [1:0]           op_kind_o,
  input wire [ADDR_BITS-1:0] op_addr_o,
  input wire                 op_done_o,
  input wire                 op_abort_o
);
  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////
  reg  [31:0] busy_cnt; // busy cycles of the running op
  wire [31:0] want_cnt; // length its kind asks for
  assign want_cnt = (op_kind_o == 2'h0) ? PROGRAM_CYC + PAGE_ERASE_CYC :
                    (op_kind_o == 2'h1) ? PROGRAM_CYC :
                    (op_kind_o == 2'h2) ? PAGE_ERASE_CYC : SUBSECTOR_CYC;
  // count busy samples from the start pulse on
  always @(posedge mclk_i) begin
    if (sys_rst_i)
      busy_cnt <= 32'h0;
    else if (op_start_o)
      busy_cnt <= 32'h1;
    else if (cycle_busy_flag_o)
      busy_cnt <= busy_cnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////
  AST_BUSY_LEN: assert property (op_done_o |-> busy_cnt == want_cnt)
    else $error("busy length does not match op kind");
  AST_START_STATE: assert property (
    op_start_o |-> cycle_busy_flag_o && !write_latch_flag_o)
    else $error("start without busy or with latch set");
  AST_BUSY_ROSE: assert property ($rose(cycle_busy_flag_o) |-> op_start_o)
    else $error("busy rose without a start");
  AST_NO_RESTART: assert property (op_start_o |-> !$past(cycle_busy_flag_o))
    else $error("new op started while busy");
  AST_HOLD_OP: assert property (cycle_busy_flag_o && !op_start_o |->
    $stable(op_kind_o) && $stable(op_addr_o))
    else $error("running op changed");
  AST_SEL_HIGH: assert property (op_start_o |-> $past(spi_cs_n_i, 4))
    else $error("op started without select rise");
  AST_ABORT_BUSY: assert property (op_abort_o |-> ##[0:3] !cycle_busy_flag_o)
    else $error("abort left busy high");
  AST_RST_MODE: assert property ($fell(hw_reset_n_i) |-> ##[1:6] reset_mode_o)
    else $error("reset mode not entered");
  AST_NO_START_RM: assert property (reset_mode_o |-> !op_start_o)
    else $error("op started in reset mode");
  AST_WEL_SET: assert property (wel_set_i && !reset_mode_o |=> write_latch_flag_o)
    else $error("latch not set");
  // main scenarios
  cover property (op_start_o && op_kind_o == 2'h0);
  cover property (op_done_o && op_kind_o == 2'h3);
  cover property (op_abort_o);
endmodule

bind sfm_top sfm_top_asserts #(
  .ADDR_BITS(ADDR_BITS), .PROGRAM_CYC(PROGRAM_CYC),
  .PAGE_ERASE_CYC(PAGE_ERASE_CYC), .SUBSECTOR_CYC(SUBSECTOR_CYC)
) u_chk (
  .mclk_i, .sys_rst_i, .spi_cs_n_i, .hw_reset_n_i, .wel_set_i,
  .write_latch_flag_o, .cycle_busy_flag_o, .reset_mode_o, .op_start_o,
  .op_kind_o, .op_addr_o, .op_done_o, .op_abort_o
);

// ---- verif/sfm_host.sv ----
`timescale 1ns/1ns
module sfm_host (
  // clock
  input wire mclk_i,
  // link pins
  output reg spi_cs_n_o,
  output reg spi_sclk_o,
  output reg sdata_o
);
  // idle: deselected, clock still
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    sdata_o    = 1'b0;
  end
  // half a link period of 160 ns
  task automatic half;
    repeat (4) @(posedge mclk_i);
  endtask
  // one frame: opcode, address, nd bytes, nx stray bits
  task automatic xfer(input [7:0] op, input [23:0] adr, input int nd,
                      input [7:0] d0, input int nx);
    logic [7:0] b;
    int j;
    int k;
    // deselect gap first, so the caller sees the start pulse after select rise
    repeat (8) @(posedge mclk_i);
    spi_cs_n_o <= 1'b0; // held low for the whole frame
    half();
    for (int i = 0; i < 32 + 8 * nd + nx; i++) begin
      j = i / 8;
      k = j - 4;
      b = (j == 0) ? op : (j < 4) ? adr[8*(3-j) +: 8] : d0 + k[7:0] + {k[8], 6'h0};
      sdata_o <= b[7 - i % 8]; // msb first
      half();
      spi_sclk_o <= 1'b1; // device takes bit on rise
      half();
      spi_sclk_o <= 1'b0;
    end
    half();
    spi_cs_n_o <= 1'b1;
    sdata_o <= ~sdata_o; // released line shows no stale bit
  endtask
endmodule

// ---- verif/sfm_top_tb_top.sv ----
`timescale 1ns/1ns
`include "sfm_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module sfm_top_tb_top;
  localparam PC = 30;  // program count, shortened
  localparam EC = 20;  // page erase count
  localparam SC = 600; // subsector count, outlasts a frame
  reg         mclk_i = 1'b0, sys_rst_i = 1'b1, hw_reset_n_i = 1'b1;
  reg         wel_set_i = 1'b0, wel_clr_i = 1'b0, hw_prot_i = 1'b0, sw_prot_i = 1'b0;
  reg  [7:0]  buf_idx_i = 8'h0;
  reg  [1:0]  lock_sector_i = 2'h0;
  wire        spi_cs_n_i, spi_sclk_i, serial_in_line_i;
  wire        write_latch_flag_o, cycle_busy_flag_o, reset_mode_o;
  wire        op_start_o, op_done_o, op_abort_o, buf_valid_o;
  wire [1:0]  op_kind_o;
  wire [17:0] op_addr_o, prot_addr_o;
  wire [7:0]  buf_data_o, lock_rd_o;
  int         n_fail = 0, cmp_count = 0, cyc = 0, w;
  logic [7:0] ops [5] = '{`SFM_OP_PAGE_PROGRAM, `SFM_OP_PAGE_PROGRAM,
    `SFM_OP_PAGE_WRITE, `SFM_OP_PAGE_ERASE, `SFM_OP_SUBSECTOR_ERASE};
  always #10 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////
  sfm_top #(.PROGRAM_CYC(PC), .PAGE_ERASE_CYC(EC), .SUBSECTOR_CYC(SC)) u_dut (
    .mclk_i, .sys_rst_i, .spi_cs_n_i, .spi_sclk_i, .serial_in_line_i, .hw_reset_n_i,
    .wel_set_i, .wel_clr_i, .hw_prot_i, .sw_prot_i, .buf_idx_i, .lock_sector_i,
    .write_latch_flag_o, .cycle_busy_flag_o, .reset_mode_o, .prot_addr_o,
    .op_start_o, .op_kind_o, .op_addr_o, .op_done_o, .op_abort_o,
    .buf_data_o, .buf_valid_o, .lock_rd_o);
  sfm_host u_host (.mclk_i, .spi_cs_n_o(spi_cs_n_i), .spi_sclk_o(spi_sclk_i),
    .sdata_o(serial_in_line_i));
  ////////////////////////////////////////////////////////////////
  // verdict
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // latch set/clear pulse, ends where flag is settled
  task automatic strobe(input [1:0] sc);
    @(posedge mclk_i);
    {wel_set_i, wel_clr_i} <= sc;
    @(posedge mclk_i);
    {wel_set_i, wel_clr_i} <= 2'b00;
    @(negedge mclk_i);
  endtask
  // present read indexes, settle one cycle
  task automatic look(input [7:0] idx, input [1:0] sec);
    @(posedge mclk_i);
    buf_idx_i <= idx;
    lock_sector_i <= sec;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  // start or no start, then busy length
  task automatic expect_op(input bit go, input [1:0] kd, input [17:0] ad, input int len);
    bit seen;
    int n;
    seen = 0;
    n = 0;
    repeat (12) if (!seen) begin
      @(negedge mclk_i);
      seen = (op_start_o === 1'b1);
    end
    `CHK(seen, go)
    if (seen) begin
      `CHK(op_kind_o, kd)
      `CHK(op_addr_o, ad)
      `CHK(write_latch_flag_o, 1'b0)
      while (len > 0 && op_done_o !== 1'b1 && n < 5000) begin
        n += cycle_busy_flag_o;
        @(negedge mclk_i);
      end
      if (len > 0) `CHK(n, len)
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    u_host.xfer(`SFM_OP_PAGE_PROGRAM, 24'h000100, 1, 8'h00, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    strobe(2'b10);
    `CHK(write_latch_flag_o, 1'b1)
    strobe(2'b01);
    `CHK(write_latch_flag_o, 1'b0)
    strobe(2'b10);
    // program crossing page end, top address bits set
    u_host.xfer(`SFM_OP_PAGE_PROGRAM, 24'hFC01FE, 4, 8'hA0, 0);
    expect_op(1, 2'h1, 18'h001FE, PC);
    `CHK(prot_addr_o, 18'h001FE)
    look(8'hFE, 2'h0);
    `CHK(buf_data_o, 8'hA0)
    look(8'h00, 2'h0);
    `CHK(buf_data_o, 8'hA2)
    look(8'h02, 2'h0);
    `CHK(buf_valid_o, 1'b0)
    // 258 bytes in one page write
    strobe(2'b10);
    u_host.xfer(`SFM_OP_PAGE_WRITE, 24'h000300, 258, 8'h10, 0);
    expect_op(1, 2'h0, 18'h00300, PC + EC);
    look(8'h00, 2'h0);
    `CHK(buf_data_o, 8'h50)
    look(8'h02, 2'h0);
    `CHK(buf_data_o, 8'h12)
    // select rises inside a byte
    strobe(2'b10);
    u_host.xfer(`SFM_OP_PAGE_PROGRAM, 24'h000400, 1, 8'h33, 3);
    expect_op(0, 2'h0, 18'h0, 0);
    `CHK(write_latch_flag_o, 1'b1)
    u_host.xfer(`SFM_OP_PAGE_ERASE, 24'h000500, 0, 8'h00, 0);
    expect_op(1, 2'h2, 18'h00500, EC);
    strobe(2'b10);
    u_host.xfer(`SFM_OP_PAGE_ERASE, 24'h000500, 1, 8'h00, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    // command while a subsector erase runs
    u_host.xfer(`SFM_OP_SUBSECTOR_ERASE, 24'h020000, 0, 8'h00, 0);
    expect_op(1, 2'h3, 18'h20000, 0);
    strobe(2'b10);
    u_host.xfer(`SFM_OP_PAGE_ERASE, 24'h000600, 0, 8'h00, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    `CHK(op_kind_o, 2'h3)
    for (w = 0; w < 1000 && op_done_o !== 1'b1; w++) @(negedge mclk_i);
    `CHK(op_done_o, 1'b1)
    // hardware reset aborts an erase
    u_host.xfer(`SFM_OP_SUBSECTOR_ERASE, 24'h030000, 0, 8'h00, 0);
    expect_op(1, 2'h3, 18'h30000, 0);
    @(posedge mclk_i);
    hw_reset_n_i <= 1'b0;
    w = 0;
    repeat (8) begin
      @(negedge mclk_i);
      w += op_abort_o;
    end
    `CHK(w, 1)
    `CHK(cycle_busy_flag_o, 1'b0)
    `CHK(reset_mode_o, 1'b1)
    @(posedge mclk_i);
    hw_reset_n_i <= 1'b1;
    repeat (1600) @(negedge mclk_i); // wait out reselect lockout
    `CHK(reset_mode_o, 1'b0)
    // protection per command
    for (int i = 0; i < 5; i++) begin
      strobe(2'b10);
      @(posedge mclk_i);
      {hw_prot_i, sw_prot_i} <= (i == 0) ? 2'b10 : 2'b01;
      u_host.xfer(ops[i], 24'h000700, i < 3, 8'h5A, 0);
      expect_op(i == 1, 2'h1, 18'h00700, PC);
    end
    @(posedge mclk_i);
    {hw_prot_i, sw_prot_i} <= 2'b00;
    // sector locks
    strobe(2'b10);
    u_host.xfer(`SFM_OP_LOCK_WRITE, 24'h010000, 1, 8'h01, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    `CHK(write_latch_flag_o, 1'b0)
    look(8'h00, 2'h1);
    `CHK(lock_rd_o, 8'h01)
    strobe(2'b10);
    u_host.xfer(`SFM_OP_PAGE_ERASE, 24'h010200, 0, 8'h00, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    u_host.xfer(`SFM_OP_LOCK_WRITE, 24'h020000, 2, 8'h00, 0);
    expect_op(0, 2'h0, 18'h0, 0);
    `CHK(write_latch_flag_o, 1'b1)
    u_host.xfer(`SFM_OP_LOCK_WRITE, 24'h02FFFF, 1, 8'h02, 0);
    strobe(2'b10);
    u_host.xfer(`SFM_OP_LOCK_WRITE, 24'h020000, 1, 8'h01, 0);
    look(8'h00, 2'h2);
    `CHK(lock_rd_o, 8'h02)
    tally_and_finish();
  end
endmodule
